// >>> pkg/sbr_pkg.sv
// constants and types for the standby release and reset control block
// Overview of operation
// - light standby instruction enters light standby, operand gives release permissions
// - operand bit 3 lets an enabled pending request end light standby
// - operand bit 1 lets the timer request end light standby regardless of enable
// - all-zero light standby operand ends only by pin or supply reset
// - light standby with a request flag already set acts as no-operation
// - request release resumes next instruction when disabled, else highest-priority vector
// - deep standby instruction enters deep standby, bit 3 allows enabled request release
// - the timer request never ends deep standby
// - all-zero deep standby ends only by reset and initialises the core
// - deep standby with a request flag already set acts as no-operation
// - deep standby resumes like light standby; reset release starts at address zero
// - three reset sources: pin, supply monitor, return stack overflow or underflow
// - pin or supply reset in standby keeps data memory and window register
// - stack reset loads stack pointer 5h, shows interrupt pin, keeps other controls
// - stack reset skips the stabilisation wait and starts at address zero
// - pin or supply reset waits 256 x 256 system clocks before running
// - deep standby clears and stops the timer; light standby leaves it running
// - deep standby stops the oscillator; light standby only gates the core clock
package sbr_pkg;
    localparam int PC_W = 12;
    localparam int NREQ = 3;
    localparam int TMR_IDX = 1;
    localparam int STAB_CLOCKS = 256 * 256;
    localparam logic [3:0] OP_ANY_REQ = 4'h8;
    localparam logic [3:0] OP_TMR_FORCE = 4'h2;
    localparam logic [3:0] SP_RESET_VAL = 4'h5;
    localparam logic [11:0] PC_RESET_VAL = 12'h000;
    // vectors by request index, index 0 is the highest priority
    localparam logic [11:0] VEC_INT = 12'h003;
    localparam logic [11:0] VEC_TMR = 12'h002;
    localparam logic [11:0] VEC_SER = 12'h001;
    // apb map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int CTRL_PDR_EN_BIT = 0;
    localparam logic CTRL_PDR_EN_RST = 1'b1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_KEEP_BIT = 8;
    localparam int ST_WAIT_BIT = 9;
    typedef enum logic [2:0] {MODE_RUN, MODE_HALT, MODE_STOP, MODE_RESET, MODE_WAIT} sbr_mode_e;
    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_PIN, CAUSE_SUPPLY, CAUSE_STACK} sbr_cause_e;
endpackage

// >>> core/sbr_top.sv
// standby entry, release, resume address and reset sequencing with apb status
`timescale 1ns/1ps
module sbr_top #(
    parameter int STAB_CYCLES = sbr_pkg::STAB_CLOCKS
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // reset sources and interrupt pin
    input wire logic EXT_RST_N,
    input wire logic POR_RST,
    input wire logic PDR_RST,
    input wire logic STACK_ERR,
    input wire logic INT_PIN,
    // instruction decoder
    input wire logic HALT_EXEC,
    input wire logic STOP_EXEC,
    input wire logic [3:0] OPERAND,
    input wire logic [sbr_pkg::PC_W-1:0] NEXT_PC,
    input wire logic GLOBAL_IRQ_EN,
    // request flags
    input wire logic [sbr_pkg::NREQ-1:0] PEND_REQ,
    input wire logic [sbr_pkg::NREQ-1:0] REQ_EN,
    // core control
    output logic CPU_CLK_EN,
    output logic OSC_RUN,
    output logic TMR_CLR,
    output logic CORE_RST,
    output logic KEEP_MEM,
    output logic PC_LOAD,
    output logic [sbr_pkg::PC_W-1:0] PC_VALUE,
    output logic SP_LOAD,
    output logic [3:0] SP_VALUE,
    output logic INT_LEVEL,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    localparam int CW = $clog2(STAB_CYCLES + 1);
    localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);

    if (STAB_CYCLES < 1) begin : g_chk
        $error("STAB_CYCLES must be at least one");
    end

    function automatic logic [sbr_pkg::PC_W-1:0] top_vector(
        input logic [sbr_pkg::NREQ-1:0] act);
        if (act[0]) top_vector = sbr_pkg::VEC_INT;
        else if (act[1]) top_vector = sbr_pkg::VEC_TMR;
        else top_vector = sbr_pkg::VEC_SER;
    endfunction

    // pin synchronisers
    logic ext_n_s1_r, ext_n_s2_r, por_s1_r, por_s2_r, pdr_s1_r, pdr_s2_r;
    logic int_s1_r, int_s2_r;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ext_n_s1_r <= 1'b1;
            ext_n_s2_r <= 1'b1;
            por_s1_r <= 1'b0;
            por_s2_r <= 1'b0;
            pdr_s1_r <= 1'b0;
            pdr_s2_r <= 1'b0;
            int_s1_r <= 1'b0;
            int_s2_r <= 1'b0;
        end else begin
            ext_n_s1_r <= EXT_RST_N;
            ext_n_s2_r <= ext_n_s1_r;
            por_s1_r <= POR_RST;
            por_s2_r <= por_s1_r;
            pdr_s1_r <= PDR_RST;
            pdr_s2_r <= pdr_s1_r;
            int_s1_r <= INT_PIN;
            int_s2_r <= int_s1_r;
        end
    end

    logic pdr_en_r;
    logic pin_rst, sup_rst, hard_rst;
    assign pin_rst = ~ext_n_s2_r;
    // the drop detector only counts while software keeps it enabled
    assign sup_rst = por_s2_r | (pdr_s2_r & pdr_en_r);
    assign hard_rst = pin_rst | sup_rst;

    // release conditions
    logic [3:0] op_r;
    logic [sbr_pkg::NREQ-1:0] active, stop_mask;
    logic any_pend, halt_rel, stop_rel;
    assign active = PEND_REQ & REQ_EN;
    assign stop_mask = ~(sbr_pkg::NREQ'(1) << sbr_pkg::TMR_IDX);
    assign any_pend = |PEND_REQ;
    assign halt_rel = (op_r[3] & (|active))
        | (op_r[1] & PEND_REQ[sbr_pkg::TMR_IDX]);
    // timer is masked out whatever the operand
    assign stop_rel = op_r[3] & (|(active & stop_mask));

    sbr_pkg::sbr_mode_e mode_r;
    sbr_pkg::sbr_cause_e cause_r;
    logic [CW-1:0] cnt_r;
    logic [sbr_pkg::PC_W-1:0] resume_r;
    logic in_standby;
    assign in_standby = (mode_r == sbr_pkg::MODE_HALT) || (mode_r == sbr_pkg::MODE_STOP);

    // sequencer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_r <= sbr_pkg::MODE_WAIT;
            cause_r <= sbr_pkg::CAUSE_SUPPLY;
            cnt_r <= '0;
            op_r <= 4'h0;
            resume_r <= sbr_pkg::PC_RESET_VAL;
            KEEP_MEM <= 1'b0;
        end else if (hard_rst) begin
            if (mode_r != sbr_pkg::MODE_RESET) begin
                KEEP_MEM <= in_standby;
            end
            mode_r <= sbr_pkg::MODE_RESET;
            cause_r <= pin_rst ? sbr_pkg::CAUSE_PIN : sbr_pkg::CAUSE_SUPPLY;
            cnt_r <= '0;
        end else begin
            case (mode_r)
                sbr_pkg::MODE_RESET: begin
                    mode_r <= sbr_pkg::MODE_WAIT;
                    cnt_r <= '0;
                end
                sbr_pkg::MODE_WAIT: begin
                    if (cnt_r == STAB_LAST) begin
                        mode_r <= sbr_pkg::MODE_RUN;
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
                sbr_pkg::MODE_RUN: begin
                    if (STACK_ERR) begin
                        cause_r <= sbr_pkg::CAUSE_STACK;
                    end else if ((HALT_EXEC || STOP_EXEC) && !any_pend) begin
                        op_r <= OPERAND;
                        resume_r <= NEXT_PC;
                        // deep standby wins when both instruction strobes arrive together
                        mode_r <= STOP_EXEC ? sbr_pkg::MODE_STOP : sbr_pkg::MODE_HALT;
                    end
                end
                sbr_pkg::MODE_HALT: begin
                    if (halt_rel) begin
                        mode_r <= sbr_pkg::MODE_RUN;
                    end
                end
                sbr_pkg::MODE_STOP: begin
                    if (stop_rel) begin
                        mode_r <= sbr_pkg::MODE_RUN;
                    end
                end
                default: mode_r <= sbr_pkg::MODE_WAIT;
            endcase
        end
    end

    // core control outputs
    logic going_halt, going_stop, release_now;
    assign going_halt = (mode_r == sbr_pkg::MODE_RUN) && HALT_EXEC && !STOP_EXEC
        && !STACK_ERR && !any_pend && !hard_rst;
    assign going_stop = (mode_r == sbr_pkg::MODE_RUN) && STOP_EXEC
        && !STACK_ERR && !any_pend && !hard_rst;
    assign release_now = !hard_rst && (((mode_r == sbr_pkg::MODE_HALT) && halt_rel)
        || ((mode_r == sbr_pkg::MODE_STOP) && stop_rel));

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CPU_CLK_EN <= 1'b0;
            OSC_RUN <= 1'b1;
            TMR_CLR <= 1'b1;
            CORE_RST <= 1'b1;
        end else begin
            // light standby only gates the core clock
            CPU_CLK_EN <= (mode_r == sbr_pkg::MODE_RUN && !going_halt && !going_stop
                && !hard_rst) || release_now || (mode_r == sbr_pkg::MODE_WAIT
                && cnt_r == STAB_LAST && !hard_rst);
            // oscillator stops in deep standby and while a hard reset is held
            OSC_RUN <= !hard_rst && !going_stop
                && !(mode_r == sbr_pkg::MODE_STOP && !stop_rel);
            // timer count cleared and held in deep standby and while a hard reset is held
            TMR_CLR <= hard_rst || going_stop
                || (mode_r == sbr_pkg::MODE_STOP && !stop_rel);
            // all-zero deep standby parks the core in its post-reset state
            CORE_RST <= hard_rst || (mode_r == sbr_pkg::MODE_RESET)
                || (mode_r == sbr_pkg::MODE_WAIT && cnt_r != STAB_LAST)
                || (going_stop && OPERAND == 4'h0)
                || (mode_r == sbr_pkg::MODE_STOP && op_r == 4'h0)
                || (mode_r == sbr_pkg::MODE_RUN && STACK_ERR && !hard_rst);
        end
    end

    // program counter redirect
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PC_LOAD <= 1'b0;
            PC_VALUE <= sbr_pkg::PC_RESET_VAL;
        end else if (!hard_rst && mode_r == sbr_pkg::MODE_WAIT && cnt_r == STAB_LAST) begin
            PC_LOAD <= 1'b1;
            PC_VALUE <= sbr_pkg::PC_RESET_VAL;
        end else if (!hard_rst && mode_r == sbr_pkg::MODE_RUN && STACK_ERR) begin
            PC_LOAD <= 1'b1;
            PC_VALUE <= sbr_pkg::PC_RESET_VAL;
        end else if (release_now) begin
            PC_LOAD <= 1'b1;
            // with interrupts on, the taken vector; otherwise the next instruction
            PC_VALUE <= (GLOBAL_IRQ_EN && |active) ? top_vector(active) : resume_r;
        end else begin
            PC_LOAD <= 1'b0;
        end
    end

    // stack fault side effects
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SP_LOAD <= 1'b0;
            SP_VALUE <= sbr_pkg::SP_RESET_VAL;
            INT_LEVEL <= 1'b0;
        end else begin
            SP_LOAD <= !hard_rst && mode_r == sbr_pkg::MODE_RUN && STACK_ERR;
            SP_VALUE <= sbr_pkg::SP_RESET_VAL;
            INT_LEVEL <= int_s2_r;
        end
    end

    // apb slave, zero wait states: ready is registered from the setup cycle and is high in the access cycle
    logic mapped;
    assign mapped = (PADDR == sbr_pkg::ADDR_CTRL) || (PADDR == sbr_pkg::ADDR_STATUS);
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                if (PADDR == sbr_pkg::ADDR_CTRL) begin
                    PRDATA[sbr_pkg::CTRL_PDR_EN_BIT] <= pdr_en_r;
                end else if (PADDR == sbr_pkg::ADDR_STATUS) begin
                    PRDATA[sbr_pkg::ST_MODE_LSB +: 3] <= mode_r;
                    PRDATA[sbr_pkg::ST_CAUSE_LSB +: 2] <= cause_r;
                    PRDATA[sbr_pkg::ST_KEEP_BIT] <= KEEP_MEM;
                    PRDATA[sbr_pkg::ST_WAIT_BIT] <= (mode_r == sbr_pkg::MODE_WAIT);
                end
            end
        end
    end

    // the enable survives a stack reset but not a pin or supply reset
    always_ff @(posedge CLK) begin
        if (SRST || hard_rst) begin
            pdr_en_r <= sbr_pkg::CTRL_PDR_EN_RST;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == sbr_pkg::ADDR_CTRL) begin
            pdr_en_r <= PWDATA[sbr_pkg::CTRL_PDR_EN_BIT];
        end
    end

    // checks
    default clocking dc @(posedge CLK); endclocking
    default disable iff (SRST);

    halt_entry_a: assert property (going_halt |=> mode_r == sbr_pkg::MODE_HALT && !CPU_CLK_EN)
        else $error("light standby not entered");
    halt_timer_a: assert property (mode_r == sbr_pkg::MODE_HALT && op_r[1]
        && PEND_REQ[sbr_pkg::TMR_IDX] && !hard_rst |=> PC_LOAD && CPU_CLK_EN)
        else $error("timer did not force light standby release");
    halt_zero_a: assert property (mode_r == sbr_pkg::MODE_HALT && op_r == 4'h0
        && !hard_rst |=> mode_r == sbr_pkg::MODE_HALT)
        else $error("empty operand light standby left without reset");
    pend_nop_a: assert property (mode_r == sbr_pkg::MODE_RUN && (HALT_EXEC || STOP_EXEC)
        && any_pend && !hard_rst |=> mode_r == sbr_pkg::MODE_RUN)
        else $error("standby entered with a request pending");
    resume_next_a: assert property (release_now && !GLOBAL_IRQ_EN
        |=> PC_LOAD && PC_VALUE == $past(resume_r))
        else $error("resume address wrong with interrupts off");
    stop_timer_a: assert property (mode_r == sbr_pkg::MODE_STOP && !(|(active & stop_mask))
        && !hard_rst |=> mode_r == sbr_pkg::MODE_STOP)
        else $error("timer ended deep standby");
    stop_osc_a: assert property (going_stop |=> !OSC_RUN && TMR_CLR
        ##1 (!OSC_RUN || PC_LOAD))
        else $error("oscillator or timer active in deep standby");
    stack_rst_a: assert property (mode_r == sbr_pkg::MODE_RUN && STACK_ERR && !hard_rst
        |=> SP_LOAD && SP_VALUE == 4'h5 && PC_LOAD && PC_VALUE == 12'h000
        ##1 (mode_r == sbr_pkg::MODE_RUN || $past(hard_rst)))
        else $error("stack reset sequence wrong");
    stab_wait_a: assert property ($rose(mode_r == sbr_pkg::MODE_WAIT) && !hard_rst
        |=> CORE_RST [*8])
        else $error("core released before stabilisation wait");
    keep_mem_a: assert property (in_standby && hard_rst && mode_r != sbr_pkg::MODE_RESET
        |=> KEEP_MEM)
        else $error("standby reset did not keep memory");
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("apb answer late");
    // deep and light standby, reset sequencing and resume vectors
    stop_entry_a: assert property (going_stop
        |=> mode_r == sbr_pkg::MODE_STOP && !CPU_CLK_EN)
        else $error("deep standby not entered");
    stop_zero_a: assert property (mode_r == sbr_pkg::MODE_STOP && op_r == 4'h0
        && !hard_rst |=> mode_r == sbr_pkg::MODE_STOP && CORE_RST)
        else $error("empty operand deep standby not held in reset");
    stack_run_a: assert property (mode_r == sbr_pkg::MODE_RUN && STACK_ERR
        && !hard_rst |=> CPU_CLK_EN && mode_r == sbr_pkg::MODE_RUN)
        else $error("stack reset inserted a wait");
    tmr_stop_a: assert property (mode_r == sbr_pkg::MODE_STOP && !stop_rel
        |=> TMR_CLR && !OSC_RUN)
        else $error("timer or oscillator running in deep standby");
    halt_osc_a: assert property (mode_r == sbr_pkg::MODE_HALT && !hard_rst
        |=> !TMR_CLR && OSC_RUN)
        else $error("light standby stopped the oscillator or timer");
    hard_hold_a: assert property (hard_rst
        |=> CORE_RST && !OSC_RUN && TMR_CLR && !CPU_CLK_EN)
        else $error("hard reset not applied");
    boot_pc_a: assert property (mode_r == sbr_pkg::MODE_WAIT && cnt_r == STAB_LAST
        && !hard_rst |=> PC_LOAD && PC_VALUE == sbr_pkg::PC_RESET_VAL
        && !CORE_RST && CPU_CLK_EN)
        else $error("start after stabilisation wait wrong");
    keep_run_a: assert property (mode_r == sbr_pkg::MODE_RUN && hard_rst
        |=> !KEEP_MEM)
        else $error("reset in operation marked memory as kept");
    halt_any_a: assert property (mode_r == sbr_pkg::MODE_HALT && op_r[3] && (|active)
        && !hard_rst |=> PC_LOAD && mode_r == sbr_pkg::MODE_RUN)
        else $error("enabled request did not end light standby");
    stop_nop_a: assert property (mode_r == sbr_pkg::MODE_RUN && STOP_EXEC && any_pend
        && !hard_rst |=> OSC_RUN && !TMR_CLR)
        else $error("deep standby entered with a request pending");
    vec_int_a: assert property (release_now && GLOBAL_IRQ_EN && active[0]
        |=> PC_LOAD && PC_VALUE == sbr_pkg::VEC_INT)
        else $error("pin request vector not taken");
    vec_tmr_a: assert property (release_now && GLOBAL_IRQ_EN && active[1:0] == 2'b10
        |=> PC_LOAD && PC_VALUE == sbr_pkg::VEC_TMR)
        else $error("timer request vector not taken");
    vec_ser_a: assert property (release_now && GLOBAL_IRQ_EN && active == 3'b100
        |=> PC_LOAD && PC_VALUE == sbr_pkg::VEC_SER)
        else $error("serial request vector not taken");

    halt_wake_c: cover property (mode_r == sbr_pkg::MODE_HALT ##1 PC_LOAD);
    stop_wake_c: cover property (mode_r == sbr_pkg::MODE_STOP ##1 PC_LOAD);
    stack_c: cover property (SP_LOAD);
    nop_c: cover property (mode_r == sbr_pkg::MODE_RUN && (HALT_EXEC || STOP_EXEC) && any_pend);
    wait_done_c: cover property (mode_r == sbr_pkg::MODE_WAIT ##1 mode_r == sbr_pkg::MODE_RUN);
endmodule

// >>> test/sbr_core_model.sv
// behavioural processor core: standby instructions, request flags and stack faults
`timescale 1ns/1ps
module sbr_core_model (
    // clock
    input wire logic clk,
    // instruction side
    output logic halt_exec,
    output logic stop_exec,
    output logic [3:0] operand,
    output logic [sbr_pkg::PC_W-1:0] next_pc,
    output logic global_irq_en,
    output logic stack_err,
    // request flags
    output logic [sbr_pkg::NREQ-1:0] pend_req,
    output logic [sbr_pkg::NREQ-1:0] req_en
);
    initial begin
        {halt_exec, stop_exec, stack_err, global_irq_en} = 4'h0;
        operand = 4'h0;
        next_pc = '0;
        pend_req = '0;
        req_en = '0;
    end
    task automatic exec(input logic deep, input logic [3:0] op, input logic [11:0] pc);
        @(posedge clk);
        stop_exec <= deep;
        halt_exec <= ~deep;
        // reserved operand bits always go out as zero
        operand <= deep ? (op & 4'h8) : (op & 4'ha);
        next_pc <= pc;
        @(posedge clk);
        {halt_exec, stop_exec} <= 2'b00;
    endtask
    task automatic requests(input logic [2:0] p, input logic [2:0] e, input logic g);
        @(posedge clk);
        pend_req <= p;
        req_en <= e;
        global_irq_en <= g;
    endtask
    task automatic stack_fault();
        @(posedge clk);
        stack_err <= 1'b1;
        @(posedge clk);
        stack_err <= 1'b0;
    endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the standby release and reset control block
`timescale 1ns/1ps
module tb;
    localparam int STAB = 10;
    logic CLK = 1'b0;
    logic SRST, EXT_RST_N, POR_RST, PDR_RST, INT_PIN, PSEL, PENABLE, PWRITE;
    logic [11:0] PADDR, NEXT_PC, PC_VALUE;
    logic [31:0] PWDATA, PRDATA, rd;
    logic HALT_EXEC, STOP_EXEC, GLOBAL_IRQ_EN, STACK_ERR, er, pin;
    logic [3:0] OPERAND, SP_VALUE;
    logic [2:0] PEND_REQ, REQ_EN;
    logic CPU_CLK_EN, OSC_RUN, TMR_CLR, CORE_RST, KEEP_MEM, PC_LOAD, SP_LOAD, INT_LEVEL;
    logic PREADY, PSLVERR;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 CLK = ~CLK;
    sbr_core_model core_u (.clk(CLK), .halt_exec(HALT_EXEC), .stop_exec(STOP_EXEC),
        .operand(OPERAND), .next_pc(NEXT_PC), .global_irq_en(GLOBAL_IRQ_EN),
        .stack_err(STACK_ERR), .pend_req(PEND_REQ), .req_en(REQ_EN));
    sbr_top #(.STAB_CYCLES(STAB)) dut_u (.CLK(CLK), .SRST(SRST), .EXT_RST_N(EXT_RST_N),
        .POR_RST(POR_RST), .PDR_RST(PDR_RST), .STACK_ERR(STACK_ERR), .INT_PIN(INT_PIN),
        .HALT_EXEC(HALT_EXEC), .STOP_EXEC(STOP_EXEC), .OPERAND(OPERAND), .NEXT_PC(NEXT_PC),
        .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .PEND_REQ(PEND_REQ), .REQ_EN(REQ_EN),
        .CPU_CLK_EN(CPU_CLK_EN), .OSC_RUN(OSC_RUN), .TMR_CLR(TMR_CLR), .CORE_RST(CORE_RST),
        .KEEP_MEM(KEEP_MEM), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .SP_LOAD(SP_LOAD),
        .SP_VALUE(SP_VALUE), .INT_LEVEL(INT_LEVEL), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR));
    // resume address: first enabled pending flag in priority order when interrupts are on
    function automatic logic [11:0] exp_pc(logic [2:0] p, logic [2:0] e, logic g,
            logic [11:0] npc);
        logic [11:0] vec [3] = '{sbr_pkg::VEC_INT, sbr_pkg::VEC_TMR, sbr_pkg::VEC_SER};
        for (int i = 0; i < 3; i++) begin
            if (g && p[i] && e[i]) return vec[i];
        end
        return npc;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // hold the request until ready is seen at a rising edge; a hang ends by the timeout
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wait_pc(input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(negedge CLK);
            if (PC_LOAD === 1'b1) break;
        end
    endtask
    task automatic boot(input logic keep);
        int n;
        wait_pc(STAB + 20, n);
        chk("wait", n >= STAB, 1);
        chk("boot pc", PC_VALUE, 0);
        chk("boot rst", CORE_RST, 0);
        chk("keep", KEEP_MEM, keep);
    endtask
    task automatic hard(input int src, input logic keep);
        @(posedge CLK);
        EXT_RST_N <= (src != 0);
        POR_RST <= (src == 1);
        PDR_RST <= (src == 2);
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("hard osc", OSC_RUN, 0);
        chk("hard rst", CORE_RST, 1);
        @(posedge CLK);
        {EXT_RST_N, POR_RST, PDR_RST} <= 3'b100;
        boot(keep);
    endtask
    task automatic sb(input logic deep, input logic [3:0] op, input logic [2:0] p,
            input logic [2:0] e, input logic g);
        logic rel;
        logic [11:0] pc;
        int n;
        pc = 12'($urandom);
        rel = deep ? (op[3] && |(p & e & 3'b101)) : ((op[3] && |(p & e)) || (op[1] && p[1]));
        core_u.exec(deep, op, pc);
        @(negedge CLK);
        chk("clk_en off", CPU_CLK_EN, 0);
        chk("osc", OSC_RUN, !deep);
        chk("tmr_clr", TMR_CLR, deep);
        chk("init", CORE_RST, deep && op == 4'h0);
        core_u.requests(p, e, g);
        wait_pc(6, n);
        chk("released", n < 6, rel);
        if (rel) begin
            chk("delay", n, 1);
            chk("resume pc", PC_VALUE, exp_pc(p, e, g, pc));
            chk("clk back", CPU_CLK_EN && OSC_RUN, 1);
        end else begin
            hard(0, 1);
        end
        core_u.requests(3'b000, 3'b000, 1'b0);
        $display("test standby %0d op %h done", deep, op);
    endtask
    initial begin
        void'($urandom(37465));
        {SRST, EXT_RST_N, POR_RST, PDR_RST, INT_PIN, PSEL, PENABLE, PWRITE} = 8'hc0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        boot(0);
        apb(0, sbr_pkg::ADDR_CTRL, 0);
        chk("ctrl reset", rd, 1);
        apb(1, sbr_pkg::ADDR_CTRL, $urandom & 32'hfffffffe);
        apb(0, sbr_pkg::ADDR_CTRL, 0);
        chk("ctrl off", rd, 0);
        @(posedge CLK);
        PDR_RST <= 1'b1;
        repeat (5) @(negedge CLK);
        chk("drop masked", CPU_CLK_EN, 1);
        @(posedge CLK);
        PDR_RST <= 1'b0;
        apb(1, sbr_pkg::ADDR_CTRL, 1);
        apb(0, 12'h008, 0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        apb(0, sbr_pkg::ADDR_STATUS, 0);
        chk("status", rd, 32'h20);
        $display("test registers done");
        sb(0, 4'h8, 3'b001, 3'b001, 1);
        sb(0, 4'h8, 3'b101, 3'b101, 1);
        sb(0, 4'h8, 3'b100, 3'b100, 0);
        sb(0, 4'h8, 3'b110, 3'b110, 1);
        sb(0, 4'h2, 3'b010, 3'b000, 1);
        sb(0, 4'h8, 3'b010, 3'b000, 1);
        sb(0, 4'h0, 3'b111, 3'b111, 1);
        sb(1, 4'h8, 3'b100, 3'b100, 1);
        sb(1, 4'h8, 3'b010, 3'b010, 1);
        sb(1, 4'h0, 3'b111, 3'b111, 0);
        for (int d = 0; d < 2; d++) begin
            core_u.requests(3'b100, 3'b000, 1'b0);
            core_u.exec(d[0], 4'h8, 12'($urandom));
            repeat (2) @(negedge CLK);
            chk("nop", CPU_CLK_EN, 1);
            core_u.requests(3'b000, 3'b000, 1'b0);
        end
        $display("test no-operation done");
        pin = 1'($urandom);
        INT_PIN <= pin;
        core_u.stack_fault();
        @(negedge CLK);
        chk("stack", {CORE_RST, SP_LOAD, SP_VALUE, PC_LOAD, PC_VALUE},
            {2'b11, sbr_pkg::SP_RESET_VAL, 1'b1, sbr_pkg::PC_RESET_VAL});
        @(negedge CLK);
        chk("no wait", {CORE_RST, CPU_CLK_EN}, 2'b01);
        apb(0, sbr_pkg::ADDR_STATUS, 0);
        chk("stack cause", rd[5:0], 6'h30);
        chk("int level", INT_LEVEL, pin);
        $display("test stack done");
        hard(1, 0);
        hard(2, 0);
        apb(0, sbr_pkg::ADDR_STATUS, 0);
        chk("supply cause", rd, 32'h20);
        $display("test hard resets done");
        tally_and_finish();
    end
endmodule
